// [event_counter_defines.svh]
`ifndef EVENT_COUNTER_DEFINES_SVH
`define EVENT_COUNTER_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_CONTROL_STATUS 4'h0
`define ADDR_UPPER_COUNT 4'h1
`define ADDR_LOWER_COUNT 4'h2

// ****************************************************************
// Control/status bit positions
// ****************************************************************
`define BIT_UPPER_OVERFLOW 7
`define BIT_LOWER_OVERFLOW 6
`define BIT_RESERVED 5
`define BIT_SPLIT_MODE 4
`define BIT_UPPER_GATE 3
`define BIT_LOWER_GATE 2
`define BIT_UPPER_RELEASE 1
`define BIT_LOWER_RELEASE 0

// ****************************************************************
// Reset values and counter limits
// ****************************************************************
`define CONTROL_STATUS_RESET 8'h00
`define COUNT_RESET 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_STEP 8'h01
`define PRESCALE_RESET 3'h0
`define PRESCALE_STEP 3'h1

// ****************************************************************
// Clock source and edge codes
// ****************************************************************
`define CLK_SEL_PIN 2'h0
`define CLK_SEL_DIV2 2'h1
`define CLK_SEL_DIV4 2'h2
`define CLK_SEL_DIV8 2'h3
`define EDGE_SEL_FALL 2'h0
`define EDGE_SEL_RISE 2'h1
`define EDGE_SEL_BOTH 2'h2

`endif

// [event_counter_pkg.sv]
package event_counter_pkg;

  typedef struct packed {
    logic upper_overflow_flag;
    logic lower_overflow_flag;
    logic reserved;
    logic split_mode_select;
    logic upper_count_gate;
    logic lower_count_gate;
    logic upper_reset_release;
    logic lower_reset_release;
  } control_status_t;

  typedef struct packed {
    control_status_t csr;
    logic [7:0] upper_count;
    logic [7:0] lower_count;
    logic [2:0] prescale;
    logic upper_flag_seen;
    logic lower_flag_seen;
    logic [7:0] read_data;
    logic irq_pulse;
  } control_state_t;

  typedef struct packed {
    logic pin_prev;
  } source_state_t;

endpackage

// [event_source_if.sv]
`timescale 1ns/1ps
interface event_source_if;
  logic pin;
  logic [1:0] clock_select;
  logic [1:0] edge_select;
  logic tick_div2;
  logic tick_div4;
  logic tick_div8;
  logic event_tick;

  modport ctrl (
    output pin,
    output clock_select,
    output edge_select,
    output tick_div2,
    output tick_div4,
    output tick_div8,
    input event_tick
  );

  modport src (
    input pin,
    input clock_select,
    input edge_select,
    input tick_div2,
    input tick_div4,
    input tick_div8,
    output event_tick
  );
endinterface

// [event_source.sv]
`timescale 1ns/1ps
`include "event_counter_defines.svh"
module event_source
  import event_counter_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  event_source_if.src link
);

  source_state_t q;
  source_state_t next_q;
  logic pin_event;

  // ****************************************************************
  // Edge detection and clock source choice
  // ****************************************************************
  always_comb
  begin
    next_q = q;
    next_q.pin_prev = link.pin;
    case (link.edge_select)
      `EDGE_SEL_FALL: pin_event = q.pin_prev & ~link.pin;
      `EDGE_SEL_RISE: pin_event = ~q.pin_prev & link.pin;
      `EDGE_SEL_BOTH: pin_event = q.pin_prev ^ link.pin;
      // The prohibited code counts nothing rather than guessing an edge.
      default: pin_event = 1'b0;
    endcase
    case (link.clock_select)
      `CLK_SEL_PIN: link.event_tick = pin_event;
      `CLK_SEL_DIV2: link.event_tick = link.tick_div2;
      `CLK_SEL_DIV4: link.event_tick = link.tick_div4;
      `CLK_SEL_DIV8: link.event_tick = link.tick_div8;
      default: link.event_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= next_q;
  end

endmodule

// [event_counter_control.sv]
// Notes on behaviour
// - Upper overflow flag sets when the upper counter wraps from FF to 00.
// - Upper flag clears only by writing 0 after reading it as 1.
// - Writing 1 to either overflow flag does nothing.
// - Lower overflow flag sets on lower wrap, only in split mode.
// - Lower flag clears only by writing 0 after reading it as 1.
// - Split select 0 chains both counters into one 16-bit counter.
// - Split select 1 runs the counters as two 8-bit channels.
// - Upper gate 0 blocks upper event clocks and holds the value.
// - Lower gate 0 blocks lower event clocks and holds the value.
// - Upper release 0 holds the upper counter at 00.
// - Lower release 0 holds the lower counter in reset.
// - Upper counter is 8-bit, read-only, standalone in split mode.
// - In combined mode the upper counter is the high byte.
// - Upper clock is its pin, a divided clock, or lower overflow.
// - Two-bit clock select: pin, divide by 2, 4 or 8.
// - Two-bit edge select: falling, rising, both; code 11 prohibited.
// - Combined wrap FFFF to 0000 sets upper flag and raises the interrupt flag.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "event_counter_defines.svh"
module event_counter_control
  import event_counter_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic upper_event_pin,
  input wire logic lower_event_pin,
  input wire logic upper_clock_select_msb,
  input wire logic upper_clock_select_lsb,
  input wire logic upper_edge_select_msb,
  input wire logic upper_edge_select_lsb,
  input wire logic [1:0] lower_clock_select,
  input wire logic [1:0] lower_edge_select,
  output logic event_counter_irq_flag,
  output logic [7:0] upper_event_count,
  output logic [7:0] lower_event_count
);

  control_state_t q;
  control_state_t next_q;

  logic [1:0] pin_bus;
  logic [1:0] clock_select_bus [2];
  logic [1:0] edge_select_bus [2];
  logic [1:0] event_bus;

  logic lower_event;
  logic lower_wrap;
  logic upper_event;
  logic upper_wrap;
  logic csr_write;
  logic csr_read;
  logic clear_upper;
  logic clear_lower;

  // ****************************************************************
  // Event sources, index 0 lower and index 1 upper
  // ****************************************************************
  assign pin_bus = {upper_event_pin, lower_event_pin};
  assign clock_select_bus[0] = lower_clock_select;
  assign clock_select_bus[1] = {upper_clock_select_msb, upper_clock_select_lsb};
  assign edge_select_bus[0] = lower_edge_select;
  assign edge_select_bus[1] = {upper_edge_select_msb, upper_edge_select_lsb};

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_source
      event_source_if link ();
      assign link.pin = pin_bus[i];
      assign link.clock_select = clock_select_bus[i];
      assign link.edge_select = edge_select_bus[i];
      assign link.tick_div2 = (q.prescale[0] == 1'b1);
      assign link.tick_div4 = (q.prescale[1:0] == 2'h3);
      assign link.tick_div8 = (q.prescale == 3'h7);
      assign event_bus[i] = link.event_tick;
      event_source u_source (
        .clk(clk),
        .reset_n(reset_n),
        .link(link.src)
      );
    end
  endgenerate

  // ****************************************************************
  // Counting, flags and register access
  // ****************************************************************
  always_comb
  begin
    next_q = q;
    next_q.prescale = q.prescale + `PRESCALE_STEP;
    next_q.irq_pulse = 1'b0;
    next_q.read_data = 8'h00;

    // Lower channel.
    lower_event = event_bus[0] & q.csr.lower_count_gate;
    lower_wrap = lower_event & q.csr.lower_reset_release & (q.lower_count == `COUNT_MAX);
    if (!q.csr.lower_reset_release)
      next_q.lower_count = `COUNT_RESET;
    else if (lower_event)
      next_q.lower_count = q.lower_count + `COUNT_STEP;

    // Upper channel: its own source when split, the lower carry when chained.
    if (q.csr.split_mode_select)
      upper_event = event_bus[1];
    else
      upper_event = lower_wrap;
    upper_event = upper_event & q.csr.upper_count_gate;
    upper_wrap = upper_event & q.csr.upper_reset_release & (q.upper_count == `COUNT_MAX);
    if (!q.csr.upper_reset_release)
      next_q.upper_count = `COUNT_RESET;
    else if (upper_event)
      next_q.upper_count = q.upper_count + `COUNT_STEP;

    // Register access decode.
    csr_write = wr & (addr == `ADDR_CONTROL_STATUS);
    csr_read = rd & (addr == `ADDR_CONTROL_STATUS);
    clear_upper = csr_write & ~wdata[`BIT_UPPER_OVERFLOW] & q.upper_flag_seen;
    clear_lower = csr_write & ~wdata[`BIT_LOWER_OVERFLOW] & q.lower_flag_seen;

    if (csr_write)
    begin
      // The reserved bit is stored as written; software keeps it at 0.
      next_q.csr.reserved = wdata[`BIT_RESERVED];
      next_q.csr.split_mode_select = wdata[`BIT_SPLIT_MODE];
      next_q.csr.upper_count_gate = wdata[`BIT_UPPER_GATE];
      next_q.csr.lower_count_gate = wdata[`BIT_LOWER_GATE];
      next_q.csr.upper_reset_release = wdata[`BIT_UPPER_RELEASE];
      next_q.csr.lower_reset_release = wdata[`BIT_LOWER_RELEASE];
    end

    // A write never stores a 1, and a new overflow beats a clear in the same cycle.
    next_q.csr.upper_overflow_flag = upper_wrap | (q.csr.upper_overflow_flag & ~clear_upper);
    next_q.csr.lower_overflow_flag = (lower_wrap & q.csr.split_mode_select)
      | (q.csr.lower_overflow_flag & ~clear_lower);
    next_q.irq_pulse = upper_wrap & ~q.csr.split_mode_select;

    // A read of the flags arms the clear; a clearing write consumes it.
    if (csr_read)
    begin
      next_q.upper_flag_seen = q.csr.upper_overflow_flag;
      next_q.lower_flag_seen = q.csr.lower_overflow_flag;
    end
    else
    begin
      if (clear_upper)
        next_q.upper_flag_seen = 1'b0;
      if (clear_lower)
        next_q.lower_flag_seen = 1'b0;
    end

    // Read data stand only in the cycle after the strobe.
    if (rd)
    begin
      case (addr)
        `ADDR_CONTROL_STATUS: next_q.read_data = q.csr;
        `ADDR_UPPER_COUNT: next_q.read_data = q.upper_count;
        `ADDR_LOWER_COUNT: next_q.read_data = q.lower_count;
        default: next_q.read_data = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q.csr <= `CONTROL_STATUS_RESET;
      q.upper_count <= `COUNT_RESET;
      q.lower_count <= `COUNT_RESET;
      q.prescale <= `PRESCALE_RESET;
      q.upper_flag_seen <= 1'b0;
      q.lower_flag_seen <= 1'b0;
      q.read_data <= 8'h00;
      q.irq_pulse <= 1'b0;
    end
    else
      q <= next_q;
  end

  assign rdata = q.read_data;
  assign event_counter_irq_flag = q.irq_pulse;
  assign upper_event_count = q.upper_count;
  assign lower_event_count = q.lower_count;

endmodule

// [event_counter_props.sv]
`timescale 1ns/1ps
module event_counter_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic event_counter_irq_flag,
  input wire logic [7:0] upper_event_count,
  input wire logic [7:0] lower_event_count
);
  // ****************************************************************
  // Read path and counter properties
  // ****************************************************************
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence read_at(logic [3:0] a);
    rd && addr == a;
  endsequence

  sequence wrap_seen;
    $past({upper_event_count, lower_event_count}) == 16'hFFFF
      && {upper_event_count, lower_event_count} == 16'h0000;
  endsequence

  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  upper_read_a: assert property (read_at(4'h1) |=> rdata == $past(upper_event_count))
    else $error("upper count read wrong");
  lower_read_a: assert property (read_at(4'h2) |=> rdata == $past(lower_event_count))
    else $error("lower count read wrong");
  unmapped_read_a: assert property (rd && addr > 4'h2 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_pulse_a: assert property (event_counter_irq_flag |=> !event_counter_irq_flag)
    else $error("interrupt pulse too long");
  irq_wrap_a: assert property (event_counter_irq_flag |-> wrap_seen)
    else $error("interrupt without full wrap");
  upper_step_a: assert property (upper_event_count != $past(upper_event_count) |->
    upper_event_count == $past(upper_event_count) + 8'h01 || upper_event_count == 8'h00)
    else $error("upper count jumped");
  lower_step_a: assert property (lower_event_count != $past(lower_event_count) |->
    lower_event_count == $past(lower_event_count) + 8'h01 || lower_event_count == 8'h00)
    else $error("lower count jumped");
endmodule

bind event_counter_control event_counter_props i_event_counter_props (.clk, .reset_n, .addr,
  .rd, .rdata, .event_counter_irq_flag, .upper_event_count, .lower_event_count);

// [event_pin_model.sv]
`timescale 1ns/1ps
module event_pin_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [3:0] gap,
  output logic upper_event_pin,
  output logic lower_event_pin
);
  // ****************************************************************
  // Event source
  // ****************************************************************
  // Both pins toggle every gap cycles while go is high and rest low otherwise.
  logic [3:0] cnt;
  logic level;
  assign upper_event_pin = level;
  assign lower_event_pin = level;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n || !go)
    begin
      cnt <= 4'h0;
      level <= 1'b0;
    end
    else if (cnt == gap - 4'h1)
    begin
      cnt <= 4'h0;
      level <= ~level;
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] gap = 4'h5;
  logic [7:0] wdata = 8'h00;
  logic upper_clock_select_msb = 1'b0;
  logic upper_clock_select_lsb = 1'b0;
  logic upper_edge_select_msb = 1'b0;
  logic upper_edge_select_lsb = 1'b0;
  logic [1:0] lower_clock_select = 2'h0;
  logic [1:0] lower_edge_select = 2'h0;
  logic [7:0] rdata, upper_event_count, lower_event_count, v, w;
  logic event_counter_irq_flag, upper_event_pin, lower_event_pin;
  int err_total = 0;
  int tests_run = 0;
  int irq_seen = 0;
  // Eight pin toggles give four falls, four rises, eight edges, or none.
  logic [7:0] edge_hits [4] = '{8'h04, 8'h04, 8'h08, 8'h00};

  always #2.5 clk = ~clk;

  // The interrupt pulse stands one cycle, so exactly one rising edge sees each pulse.
  always @(posedge clk)
  begin
    if (event_counter_irq_flag === 1'b1)
      irq_seen++;
  end

  event_counter_control i_event_counter_control (.clk, .reset_n, .addr, .wdata, .wr, .rd,
    .rdata, .upper_event_pin, .lower_event_pin, .upper_clock_select_msb,
    .upper_clock_select_lsb, .upper_edge_select_msb, .upper_edge_select_lsb,
    .lower_clock_select, .lower_edge_select, .event_counter_irq_flag, .upper_event_count,
    .lower_event_count);
  event_pin_model i_event_pin_model (.clk, .reset_n, .go, .gap, .upper_event_pin,
    .lower_event_pin);

  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A free cycle follows each strobe so no strobe is assigned twice in one step.
  task write(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task read(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task reset_values;
    read(4'h0, v);
    check(v, 8'h00);
    write(4'h0, 8'hDF);
    read(4'h0, v);
    check(v, 8'h1F);
    read(4'h7, v);
    check(v, 8'h00);
  endtask

  task clock_dividers;
    write(4'h0, 8'h1A);
    for (int c = 1; c < 4; c++)
    begin
      {upper_clock_select_msb, upper_clock_select_lsb} <= c[1:0];
      read(4'h1, v);
      repeat (6) @(posedge clk);
      read(4'h1, w);
      check(8'(w - v), 8'h08 >> c);
    end
    write(4'h0, 8'h12);
    read(4'h1, v);
    repeat (6) @(posedge clk);
    read(4'h1, w);
    check(w, v);
    write(4'h0, 8'h18);
    read(4'h1, v);
    check(v, 8'h00);
  endtask

  task pin_edges;
    {upper_clock_select_msb, upper_clock_select_lsb} <= 2'h0;
    for (int e = 0; e < 4; e++)
    begin
      {upper_edge_select_msb, upper_edge_select_lsb} <= e[1:0];
      lower_edge_select <= e[1:0];
      write(4'h0, 8'h1C);
      write(4'h0, 8'h1F);
      go <= 1'b1;
      repeat (42) @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      read(4'h1, v);
      check(v, edge_hits[e]);
      read(4'h2, v);
      check(v, edge_hits[e]);
    end
  endtask

  task overflow_flags;
    {upper_clock_select_msb, upper_clock_select_lsb} <= 2'h1;
    lower_clock_select <= 2'h1;
    write(4'h0, 8'h1C);
    write(4'h0, 8'h1F);
    repeat (600) @(posedge clk);
    write(4'h0, 8'h1F);
    read(4'h0, v);
    check(v, 8'hDF);
    write(4'h0, 8'h1F);
    read(4'h0, v);
    check(v, 8'h1F);
  endtask

  task combined_carry;
    write(4'h0, 8'h00);
    write(4'h0, 8'h0F);
    repeat (600) @(posedge clk);
    read(4'h1, v);
    check(v, 8'h01);
    read(4'h0, v);
    check(v, 8'h0F);
    check(8'(irq_seen), 8'h00);
  endtask

  // The upper counter is walked to FF alone on rising pin edges, then chained so that
  // a single lower wrap carries the whole 16-bit value through FFFF to 0000.
  task full_wrap;
    {upper_clock_select_msb, upper_clock_select_lsb} <= 2'h0;
    {upper_edge_select_msb, upper_edge_select_lsb} <= 2'h1;
    gap <= 4'h1;
    write(4'h0, 8'h1C);
    write(4'h0, 8'h1B);
    go <= 1'b1;
    repeat (510) @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    read(4'h1, v);
    check(v, 8'hFF);
    read(4'h2, v);
    check(v, 8'h00);
    write(4'h0, 8'h0F);
    repeat (600) @(posedge clk);
    read(4'h1, v);
    check(v, 8'h00);
    read(4'h0, v);
    check(v, 8'h8F);
    check(8'(irq_seen), 8'h01);
  endtask

  task conclude;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    reset_values();
    clock_dividers();
    pin_edges();
    overflow_flags();
    combined_carry();
    full_wrap();
    conclude();
  end
endmodule
